// ==== pkg/arpf_pkg.sv ====
// Constants and types for the automatic-mode radio pipe controller
`default_nettype none
package arpf_pkg;
  // Clock and timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int PAIR_HOLD_MS  = 160;
  localparam int UART_BAUD     = 115_200;
  localparam int BAUD_CYC      = CLK_HZ / UART_BAUD;
  localparam int HALF_BAUD_CYC = BAUD_CYC / 2;
  localparam int UART_BITS     = 8;

  // Register byte addresses
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_STATUS   = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0C;
  localparam logic [4:0] REG_STBY_TMO = 5'h10;

  // Control fields
  localparam int CTRL_W        = 5;
  localparam int CTRL_AUTO     = 0;
  localparam int CTRL_FLOW     = 1;
  localparam int CTRL_DROP_EN  = 2;
  localparam int CTRL_UNPAIR_EN= 3;
  localparam int CTRL_WAKE_EN  = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h1D;

  // Interrupt events
  localparam int IRQ_W         = 5;
  localparam int IRQ_LINK_UP   = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_SHUTDOWN  = 2;
  localparam int IRQ_WAKE      = 3;
  localparam int IRQ_OVERRUN   = 4;

  localparam int TMO_W = 16;
  localparam logic [TMO_W-1:0] TMO_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] DISC_BOTH   = 2'h3;

  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_STBY = 4'h2,
    ST_LINK = 4'h4,
    ST_SHUT = 4'h8
  } arpf_state_t;
endpackage : arpf_pkg
`default_nettype wire

// ==== sim/arpf_host_model.sv ====
// Host controller model: UART sender and receiver, 8N1, LSB first
`default_nettype none
module arpf_host_model
  import arpf_pkg::*;
#(
  parameter int BIT_CYC = BAUD_CYC
) (
  // Clock
  input  wire logic aclk,
  // UART lines
  input  wire logic uart_txd,
  output var  logic uart_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rxd <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask

  // Bytes with a bad stop bit are not queued
  initial begin : rx_loop
    logic [7:0] b;
    uart_rxd = 1'b1;
    forever begin
      @(negedge uart_txd);
      repeat (BIT_CYC / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge aclk);
        b[i] = uart_txd;
      end
      repeat (BIT_CYC) @(posedge aclk);
      if (uart_txd === 1'b1) rx_q.push_back(b);
    end
  end
endmodule // arpf_host_model
`default_nettype wire

// ==== sim/arpf_properties.sv ====
// Concurrent checks on the pin, radio and pipe ports of the controller
`default_nettype none
module arpf_checker
  import arpf_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Host pins
  input wire logic       unpair_n,
  input wire logic       link_drop_n,
  input wire logic       wake_n,
  input wire logic       state_ind_pin_a,
  input wire logic       state_ind_pin_b,
  // Radio side
  input wire logic       radio_paired,
  input wire logic       radio_peer_lost,
  input wire logic       radio_session_open,
  input wire logic       radio_adv_en,
  input wire logic [1:0] radio_disc_mode,
  input wire logic       radio_disconnect,
  input wire logic       radio_sleep,
  // Pipe towards the peer
  input wire logic [7:0] pipe_tx_data,
  input wire logic       pipe_tx_valid,
  input wire logic       pipe_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int  low_cnt;
  wire in_stby = state_ind_pin_a & ~state_ind_pin_b;
  wire in_link = ~state_ind_pin_a;

  // Cycles the unpair pin has been low while linked
  always_ff @(posedge aclk) begin
    if (!aresetn || unpair_n || !in_link) low_cnt <= 0;
    else if (low_cnt < 100000) low_cnt <= low_cnt + 1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_to_shut;
    radio_disconnect && radio_sleep && state_ind_pin_a && state_ind_pin_b
    ##1 !radio_disconnect;
  endsequence
  sequence s_to_stby;
    in_stby && radio_adv_en && !radio_sleep;
  endsequence

  property p_pair;
    in_stby && radio_paired |=> in_link && !radio_adv_en;
  endproperty
  a_pair: assert property (p_pair)
    else $error("pairing did not reach link");
  property p_adv;
    (in_stby == radio_adv_en) &&
    (radio_disc_mode == (in_stby ? DISC_BOTH : 2'h0));
  endproperty
  a_adv: assert property (p_adv)
    else $error("advertising out of step with standby");
  property p_drop;
    in_link && !link_drop_n |=> s_to_shut;
  endproperty
  a_drop: assert property (p_drop)
    else $error("link drop did not shut down");
  property p_lost;
    in_link && link_drop_n && radio_peer_lost |=> s_to_stby;
  endproperty
  a_lost: assert property (p_lost)
    else $error("peer loss did not return to standby");
  property p_sleep;
    radio_sleep |-> state_ind_pin_a && state_ind_pin_b && !radio_adv_en;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep with wrong indication or radio on");
  property p_hold_sleep;
    radio_sleep && wake_n |=> radio_sleep;
  endproperty
  a_hold_sleep: assert property (p_hold_sleep)
    else $error("left sleep without wake");
  property p_wake;
    radio_sleep && !wake_n |=> s_to_stby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not reach standby");
  property p_session;
    in_link && link_drop_n && unpair_n && !radio_peer_lost &&
    radio_session_open |=> in_link && state_ind_pin_b;
  endproperty
  a_session: assert property (p_session)
    else $error("open session not shown on indication");
  property p_unpair_min;
    in_link && link_drop_n && !radio_peer_lost &&
    low_cnt < (PAIR_HOLD_MS - 1) * MS_CYCLES |=> in_link;
  endproperty
  a_unpair_min: assert property (p_unpair_min)
    else $error("unpair acted too early");
  property p_unpair_max;
    low_cnt >= (PAIR_HOLD_MS + 2) * MS_CYCLES |-> !in_link;
  endproperty
  a_unpair_max: assert property (p_unpair_max)
    else $error("unpair hold ignored");
  property p_tx_hold;
    pipe_tx_valid && !pipe_tx_ready |=>
      (pipe_tx_valid && $stable(pipe_tx_data)) || !in_link;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("pipe byte lost before taken");
endmodule // arpf_checker

bind arpf_top arpf_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .unpair_n(unpair_n),
  .link_drop_n(link_drop_n), .wake_n(wake_n),
  .state_ind_pin_a(state_ind_pin_a), .state_ind_pin_b(state_ind_pin_b),
  .radio_paired(radio_paired), .radio_peer_lost(radio_peer_lost),
  .radio_session_open(radio_session_open), .radio_adv_en(radio_adv_en),
  .radio_disc_mode(radio_disc_mode), .radio_disconnect(radio_disconnect),
  .radio_sleep(radio_sleep), .pipe_tx_data(pipe_tx_data),
  .pipe_tx_valid(pipe_tx_valid), .pipe_tx_ready(pipe_tx_ready)
);
`default_nettype wire

// ==== sim/arpf_top_test.sv ====
// Self-checking bench for the radio pipe controller
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module arpf_top_test;
  import arpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, rxd, txd, rts;
  logic        drop_n, unpair_n, wake_n, ind_a, ind_b, irq, paired, lost;
  logic        sess, adv, disc, sleep, txv, txr, rxv, rxr, m, cts;
  logic [1:0]  bresp, rresp, dmode;
  logic [4:0]  awaddr, araddr;
  logic [7:0]  txdat, rxdat;
  logic [31:0] wdata, rdata, v;
  logic [7:0]  tx_q[$];
  int          num_errors = 0;
  int          n_checks = 0;
  int          n;

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  arpf_top #(.MS_CYCLES(MS)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .uart_rxd(rxd),
    .uart_txd(txd), .uart_cts(cts), .uart_rts(rts),
    .link_drop_n(drop_n), .unpair_n(unpair_n), .wake_n(wake_n),
    .state_ind_pin_a(ind_a), .state_ind_pin_b(ind_b), .irq(irq),
    .radio_paired(paired), .radio_peer_lost(lost),
    .radio_session_open(sess), .radio_adv_en(adv), .radio_disc_mode(dmode),
    .radio_disconnect(disc), .radio_sleep(sleep), .pipe_tx_data(txdat),
    .pipe_tx_valid(txv), .pipe_tx_ready(txr), .pipe_rx_data(rxdat),
    .pipe_rx_valid(rxv), .pipe_rx_ready(rxr)
  );
  arpf_host_model host_u (.aclk(aclk), .uart_txd(txd), .uart_rxd(rxd));

  // Bytes taken by the peer side
  always @(posedge aclk) if (txv === 1'b1 && txr) tx_q.push_back(txdat);

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      $display("mismatch t=%0t wait expired", $time);
      tally_and_finish();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    bready <= 1'b0;
    tmo(k, 50);
    `CHK(bresp, er)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    rready <= 1'b0;
    d = rdata;
    tmo(k, 50);
    `CHK(rresp, er)
    @(posedge aclk);
  endtask
  task automatic ind(input logic [1:0] e);
    `CHK({ind_a, ind_b}, e)
  endtask
  task automatic pair;
    paired <= 1'b1;
    @(posedge aclk);
    paired <= 1'b0;
    cyc(2);
    ind(2'b00);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {paired, lost, sess, txr, rxv, cts} = '0;
    {drop_n, unpair_n, wake_n} = 3'h7;
    {awaddr, araddr, wdata, rxdat} = '0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(3);
    ind(2'b10);
    `CHK({adv, dmode}, {1'b1, DISC_BOTH})
    rd(REG_CTRL, v, RESP_OKAY);
    `CHK(v, 32'(CTRL_RESET))
    rd(5'h14, v, RESP_SLVERR);
    `CHK(v, 32'h0)
    wr(5'h14, 32'h1, RESP_SLVERR);
    $display("test standby done");
    pair();
    `CHK({adv, dmode, sleep}, 4'h0)
    sess <= 1'b1;
    cyc(2);
    ind(2'b01);
    wr(REG_STATUS, 32'h0, RESP_OKAY);
    rd(REG_STATUS, v, RESP_OKAY);
    `CHK(v[3:0], 4'h4)
    rd(REG_IRQ_STAT, v, RESP_OKAY);
    `CHK(v[IRQ_LINK_UP], 1'b1)
    wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    cyc(2);
    m = irq;
    wr(REG_IRQ_MASK, 32'h1F, RESP_OKAY);
    cyc(2);
    `CHK(m, 1'b0)
    `CHK(irq, 1'b1)
    wr(REG_IRQ_STAT, 32'h1F, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    rd(REG_IRQ_STAT, v, RESP_OKAY);
    `CHK(v, 32'h0)
    $display("test link and interrupt done");
    wr(REG_CTRL, 32'(CTRL_RESET) | (32'h1 << CTRL_FLOW), RESP_OKAY);
    cts <= 1'b1;
    fork
      begin
        host_u.send(8'hAA);
        host_u.send(8'h01);
      end
      begin
        rxdat <= 8'h5C;
        rxv <= 1'b1;
        n = 0;
        do begin
          @(posedge aclk);
          n++;
        end while (!rxr && n < 3000);
        rxv <= 1'b0;
        tmo(n, 3000);
      end
      begin
        cyc(1000);
        `CHK(rts, 1'b1)
        `CHK(host_u.rx_q.size(), 0)
        txr <= 1'b1;
        cts <= 1'b0;
      end
    join
    cyc(200);
    `CHK(rts, 1'b0)
    `CHK(tx_q.size(), 2)
    `CHK(tx_q[0], 8'hAA)
    `CHK(tx_q[1], 8'h01)
    `CHK(host_u.rx_q.size(), 1)
    `CHK(host_u.rx_q[0], 8'h5C)
    $display("test pipe done");
    lost <= 1'b1;
    @(posedge aclk);
    lost <= 1'b0;
    sess <= 1'b0;
    cyc(2);
    ind(2'b10);
    `CHK(adv, 1'b1)
    $display("test peer loss done");
    pair();
    unpair_n <= 1'b0;
    cyc((PAIR_HOLD_MS - 2) * MS);
    ind(2'b00);
    n = 0;
    while (ind_a !== 1'b1 && n < 5 * MS) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 5 * MS);
    unpair_n <= 1'b1;
    cyc(1);
    ind(2'b10);
    $display("test unpair done");
    pair();
    drop_n <= 1'b0;
    @(posedge aclk);
    drop_n <= 1'b1;
    cyc(2);
    ind(2'b11);
    `CHK(sleep, 1'b1)
    host_u.send(8'h33);
    cyc(5);
    `CHK(tx_q.size(), 2)
    `CHK(sleep, 1'b1)
    wake_n <= 1'b0;
    @(posedge aclk);
    wake_n <= 1'b1;
    cyc(2);
    ind(2'b10);
    `CHK(sleep, 1'b0)
    wr(REG_STBY_TMO, 32'h1, RESP_OKAY);
    cyc(3 * MS);
    ind(2'b11);
    $display("test shutdown and wake done");
    tally_and_finish();
  end
endmodule // arpf_top_test
`default_nettype wire

// ==== src/arpf_top.sv ====
// Automatic-mode radio pipe controller with AXI4-Lite control registers
//
// Operation
// - Host UART bytes received in link go to the radio peer; one arriving while the held pipe byte is not yet taken is dropped.
// - Every peer payload byte goes out on the UART transmit line.
// - Host command frames are not decoded; they pass as plain payload.
// - Peripheral role only, connectable advertising, never initiates.
// - Both limited and general discoverable procedures are used.
// - All payload uses one private pipe service channel.
// - Standby sends undirected advertising from stored configuration.
// - Pairing happens in standby; success moves to link.
// - Indication pins are updated on every state transition.
// - Shutdown stops radio activity and holds sleep until woken.
// - States run autonomously, needing only documented pin events.
// - Link supports both directions of payload at once.
// - Indication: HH shutdown, HL standby, LL link, LH session.
// - Flow control: RTS when buffer full; stop within two bytes of CTS.
`default_nettype none
module arpf_top
  import arpf_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host UART and discrete pins
  input  wire logic        uart_rxd,
  output var  logic        uart_txd,
  input  wire logic        uart_cts,
  output var  logic        uart_rts,
  input  wire logic        link_drop_n,
  input  wire logic        unpair_n,
  input  wire logic        wake_n,
  output var  logic        state_ind_pin_a,
  output var  logic        state_ind_pin_b,
  output var  logic        irq,
  // Radio link layer: events and control
  input  wire logic        radio_paired,
  input  wire logic        radio_peer_lost,
  input  wire logic        radio_session_open,
  output var  logic        radio_adv_en,
  output var  logic [1:0]  radio_disc_mode,
  output var  logic        radio_disconnect,
  output var  logic        radio_sleep,
  // Pipe service byte channels
  output var  logic [7:0]  pipe_tx_data,
  output var  logic        pipe_tx_valid,
  input  wire logic        pipe_tx_ready,
  input  wire logic [7:0]  pipe_rx_data,
  input  wire logic        pipe_rx_valid,
  output var  logic        pipe_rx_ready
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [4:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_IRQ_STAT) ||
           (a == REG_IRQ_MASK) || (a == REG_STBY_TMO);
  endfunction

  arpf_state_t         state;
  arpf_state_t         next_state;
  logic [CTRL_W-1:0]   ctrl;
  logic [IRQ_W-1:0]    irq_stat;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    irq_event;
  logic [TMO_W-1:0]    stby_tmo;
  logic [TMO_W-1:0]    stby_ms;
  logic [4:0]          aw_addr;
  logic                aw_got;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_got;
  logic                wr_commit;
  logic [31:0]         wr_val;
  logic [31:0]         rd_val;
  logic [13:0]         ms_cnt;
  logic                ms_tick;
  logic [7:0]          pair_ms;
  logic                unpair_fire;
  logic                drop_fire;
  logic                wake_fire;
  logic                rx_done;
  logic [7:0]          rx_shift;
  logic                rx_busy;
  logic [3:0]          rx_bit;
  logic [7:0]          rx_cnt;
  logic [7:0]          p2h_data;
  logic                p2h_full;
  logic [9:0]          tx_shift;
  logic [3:0]          tx_bit;
  logic [7:0]          tx_cnt;
  logic                tx_busy;
  logic                tx_start;

  // AXI4-Lite write channel: address and data taken in either order
  assign wr_commit = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (wr_commit) begin
        aw_got        <= 1'b0;
        w_got         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got        <= 1'b1;
          aw_addr       <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got        <= 1'b1;
          w_data       <= s_axi_wdata;
          w_strb       <= s_axi_wstrb;
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    wr_val = '0;
    case (aw_addr)
      REG_CTRL:     wr_val = {{(32-CTRL_W){1'b0}}, ctrl};
      REG_IRQ_MASK: wr_val = {{(32-IRQ_W){1'b0}}, irq_mask};
      REG_STBY_TMO: wr_val = {{(32-TMO_W){1'b0}}, stby_tmo};
      default:      wr_val = '0;
    endcase
    wr_val = merge_bytes(wr_val, w_data, w_strb);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= CTRL_RESET;
      irq_mask <= '0;
      stby_tmo <= TMO_RESET;
    end else if (wr_commit) begin
      case (aw_addr)
        REG_CTRL:     ctrl     <= wr_val[CTRL_W-1:0];
        REG_IRQ_MASK: irq_mask <= wr_val[IRQ_W-1:0];
        REG_STBY_TMO: stby_tmo <= wr_val[TMO_W-1:0];
        default:      ;
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else if (wr_commit && aw_addr == REG_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wr_val[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // AXI4-Lite read channel
  always_comb begin
    case (s_axi_araddr)
      REG_CTRL:     rd_val = {{(32-CTRL_W){1'b0}}, ctrl};
      REG_STATUS:   rd_val = {20'h00000, uart_rts, p2h_full, pipe_tx_valid,
                              radio_session_open, state_ind_pin_a,
                              state_ind_pin_b, 2'h0, state};
      REG_IRQ_STAT: rd_val = {{(32-IRQ_W){1'b0}}, irq_stat};
      REG_IRQ_MASK: rd_val = {{(32-IRQ_W){1'b0}}, irq_mask};
      REG_STBY_TMO: rd_val = {{(32-TMO_W){1'b0}}, stby_tmo};
      default:      rd_val = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Millisecond time base for pin hold and standby timeout
  assign ms_tick = (ms_cnt == 14'(MS_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || ms_tick) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 14'h0001;
    end
  end

  // Unpair pin must stay low a full hold time in link
  always_ff @(posedge aclk) begin
    if (!aresetn || unpair_n || state != ST_LINK) begin
      pair_ms <= '0;
    end else if (ms_tick && pair_ms != 8'(PAIR_HOLD_MS)) begin
      pair_ms <= pair_ms + 8'h01;
    end
  end

  assign unpair_fire = ctrl[CTRL_UNPAIR_EN] &&
                       (pair_ms == 8'(PAIR_HOLD_MS));
  assign drop_fire   = ctrl[CTRL_DROP_EN] && !link_drop_n;
  assign wake_fire   = ctrl[CTRL_WAKE_EN] && !wake_n;

  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_STBY) begin
      stby_ms <= '0;
    end else if (ms_tick) begin
      stby_ms <= stby_ms + 16'h0001;
    end
  end

  // Autonomous state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:  if (ctrl[CTRL_AUTO]) next_state = ST_STBY;
      ST_STBY: begin
        if (radio_paired) begin
          next_state = ST_LINK;
        end else if (stby_tmo != '0 && stby_ms >= stby_tmo) begin
          next_state = ST_SHUT;
        end
      end
      ST_LINK: begin
        if (drop_fire) begin
          next_state = ST_SHUT;
        end else if (unpair_fire || radio_peer_lost) begin
          next_state = ST_STBY;
        end
      end
      ST_SHUT: if (wake_fire) next_state = ST_STBY;
      default: next_state = ST_OFF;
    endcase
    if (!ctrl[CTRL_AUTO]) begin
      next_state = ST_OFF;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LINK_UP]   = (state != ST_LINK) && (next_state == ST_LINK);
    irq_event[IRQ_LINK_DOWN] = (state == ST_LINK) && (next_state != ST_LINK);
    irq_event[IRQ_SHUTDOWN]  = (state != ST_SHUT) && (next_state == ST_SHUT);
    irq_event[IRQ_WAKE]      = (state == ST_SHUT) && (next_state == ST_STBY);
    irq_event[IRQ_OVERRUN]   = rx_done && (state == ST_LINK) &&
                               pipe_tx_valid && !pipe_tx_ready;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Radio control and indication pins follow the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      radio_adv_en     <= 1'b0;
      radio_disc_mode  <= 2'h0;
      radio_disconnect <= 1'b0;
      radio_sleep      <= 1'b0;
      state_ind_pin_a  <= 1'b1;
      state_ind_pin_b  <= 1'b1;
    end else begin
      radio_adv_en     <= (next_state == ST_STBY);
      radio_disc_mode  <= (next_state == ST_STBY) ? DISC_BOTH : 2'h0;
      radio_disconnect <= (state == ST_LINK) && (next_state != ST_LINK) &&
                          !radio_peer_lost;
      radio_sleep      <= (next_state == ST_SHUT);
      case (next_state)
        ST_STBY: begin
          state_ind_pin_a <= 1'b1;
          state_ind_pin_b <= 1'b0;
        end
        ST_LINK: begin
          state_ind_pin_a <= 1'b0;
          state_ind_pin_b <= radio_session_open;
        end
        default: begin
          state_ind_pin_a <= 1'b1;
          state_ind_pin_b <= 1'b1;
        end
      endcase
    end
  end

  // UART receiver; bytes are never parsed for commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy  <= 1'b0;
      rx_bit   <= '0;
      rx_cnt   <= '0;
      rx_shift <= '0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!uart_rxd) begin
          rx_busy <= 1'b1;
          rx_bit  <= '0;
          rx_cnt  <= 8'(HALF_BAUD_CYC);
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 8'h01;
      end else begin
        rx_cnt <= 8'(BAUD_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && uart_rxd) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == 4'(UART_BITS + 1)) begin
          rx_busy <= 1'b0;
          rx_done <= uart_rxd;
        end else if (rx_bit != 4'h0) begin
          rx_shift <= {uart_rxd, rx_shift[7:1]};
        end
      end
    end
  end

  // Host-to-peer holding byte on the pipe service
  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_LINK) begin
      pipe_tx_valid <= 1'b0;
      pipe_tx_data  <= '0;
    end else if (rx_done && (!pipe_tx_valid || pipe_tx_ready)) begin
      pipe_tx_valid <= 1'b1;
      pipe_tx_data  <= rx_shift;
    end else if (pipe_tx_ready) begin
      pipe_tx_valid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_rts <= 1'b0;
    end else begin
      uart_rts <= ctrl[CTRL_FLOW] && pipe_tx_valid;
    end
  end

  // Peer-to-host holding byte
  assign tx_start = p2h_full && !tx_busy &&
                    !(ctrl[CTRL_FLOW] && uart_cts);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p2h_full      <= 1'b0;
      p2h_data      <= '0;
      pipe_rx_ready <= 1'b0;
    end else begin
      if (pipe_rx_valid && pipe_rx_ready) begin
        p2h_full <= 1'b1;
        p2h_data <= pipe_rx_data;
      end else if (tx_start) begin
        p2h_full <= 1'b0;
      end
      pipe_rx_ready <= (next_state == ST_LINK) && !p2h_full &&
                       !(pipe_rx_valid && pipe_rx_ready);
    end
  end

  // UART transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy  <= 1'b0;
      tx_shift <= '1;
      tx_bit   <= '0;
      tx_cnt   <= '0;
      uart_txd <= 1'b1;
    end else if (!tx_busy) begin
      uart_txd <= 1'b1;
      if (tx_start) begin
        tx_busy  <= 1'b1;
        tx_shift <= {1'b1, p2h_data, 1'b0};
        tx_bit   <= '0;
        tx_cnt   <= '0;
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - 8'h01;
    end else begin
      uart_txd <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_cnt   <= 8'(BAUD_CYC - 1);
      tx_bit   <= tx_bit + 4'h1;
      if (tx_bit == 4'(UART_BITS + 2)) begin
        tx_busy  <= 1'b0;
      end
    end
  end

endmodule // arpf_top
`default_nettype wire
